// ==== ssrs_ramp_shaper.sv ====
// speed setpoint ramp shaper with avalon register slave
// Operation
// (R01) active flag high while |output - modifier demand| exceeds activity threshold
// (R02) with drive enabled, demand magnitude is raised to the minimum-speed floor
// (R03) rise_time sets full 100 % traverse, 0.1 to 600.0 s
// (R04) fall_time sets full 100 % decrease, 0.1 to 600.0 s
// (R05) nonzero s-curve stretches time by (1 + 3.5 * s / 100)
// (R06) zero s-curve is linear; up to 100 % rounds start and end
// (R07) hold freezes output; release resumes; any reset beats hold
// (R08) invert negates the demand before ramping, else it passes unchanged
// (R09) output slews toward demand at the programmed rate, never steps
// (R10) auto reset loads preload each time the drive becomes enabled
// (R11) disabling the drive never triggers the auto reset
// (R12) auto reset fires from a run-start flag lasting one update cycle
// (R13) external reset holds output at preload, regardless of auto reset
// (R14) after external reset release, ramp resumes from preload
// (R15) external reset is a level input driven by upstream logic
// (R16) step derived from span, time and update period; no overshoot
// (R17) rise time used moving away from zero, fall time toward zero
`timescale 1ns/10ps
`include "ssrs_defines.svh"
`default_nettype none
module ssrs_ramp_shaper
  import ssrs_pkg::*;
#(
  parameter int unsigned UPDATE_CYCLES = `SSRS_UPDATE_CYCLES
)(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire ssrs_pct_t   inching_modifier_out,
  input  wire logic        drive_enable,
  input  wire logic        ext_reset,
  output ssrs_pct_t        ramp_output,
  output var  logic        ramp_active,
  output logic             irq
);
  localparam int CW = $clog2(UPDATE_CYCLES + 1);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic ssrs_word_t be_merge(input ssrs_word_t old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    be_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : be_merge

  function automatic ssrs_word_t clamp_u(input ssrs_word_t v,
                                         input ssrs_word_t lo,
                                         input ssrs_word_t hi);
    clamp_u = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp_u

  // ----------------------------------------
  // avalon slave, one wait state
  // ----------------------------------------
  logic       ack_r;
  logic [31:0] rd_mux;
  wire        req      = avs_read | avs_write;
  wire        wr_go    = avs_write & ack_r;
  wire        rd_first = avs_read & ~ack_r;
  assign avs_waitrequest = req & ~ack_r;

  wire sel_ctrl   = avs_address == `SSRS_OFF_CTRL;
  wire sel_rise   = avs_address == `SSRS_OFF_RISE;
  wire sel_fall   = avs_address == `SSRS_OFF_FALL;
  wire sel_scurve = avs_address == `SSRS_OFF_SCURVE;
  wire sel_thresh = avs_address == `SSRS_OFF_THRESH;
  wire sel_pre    = avs_address == `SSRS_OFF_PRELOAD;
  wire sel_minspd = avs_address == `SSRS_OFF_MINSPD;
  wire sel_status = avs_address == `SSRS_OFF_STATUS;
  wire sel_output = avs_address == `SSRS_OFF_OUTPUT;
  wire sel_istat  = avs_address == `SSRS_OFF_IRQ_STAT;
  wire sel_imask  = avs_address == `SSRS_OFF_IRQ_MASK;

  ssrs_word_t ctrl_r;
  ssrs_word_t rise_r;
  ssrs_word_t fall_r;
  ssrs_word_t scurve_r;
  ssrs_word_t thresh_r;
  ssrs_pct_t  preload_r;
  ssrs_word_t minspd_r;
  logic [2:0] mask_r;
  logic [2:0] istat_r;
  logic       run_start_r;

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      ack_r <= 1'b0;
    else
      ack_r <= req & ~ack_r;
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  wire ssrs_word_t wmerge_rise   = be_merge(rise_r, avs_writedata, avs_byteenable);
  wire ssrs_word_t wmerge_fall   = be_merge(fall_r, avs_writedata, avs_byteenable);
  wire ssrs_word_t wmerge_scurve = be_merge(scurve_r, avs_writedata, avs_byteenable);
  wire ssrs_word_t wmerge_thresh = be_merge(thresh_r, avs_writedata, avs_byteenable);

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      ctrl_r    <= `SSRS_RST_CTRL;
      rise_r    <= `SSRS_RST_RISE;
      fall_r    <= `SSRS_RST_FALL;
      scurve_r  <= `SSRS_RST_SCURVE;
      thresh_r  <= `SSRS_RST_THRESH;
      preload_r <= `SSRS_RST_PRELOAD;
      minspd_r  <= `SSRS_RST_MINSPD;
      mask_r    <= `SSRS_RST_MASK;
    end
    else if (wr_go)
    begin
      if (sel_ctrl)
        ctrl_r <= be_merge(ctrl_r, avs_writedata, avs_byteenable) & 16'h0007;
      // (R03) rise time kept in range
      if (sel_rise)
        rise_r <= clamp_u(wmerge_rise, `SSRS_TIME_MIN, `SSRS_TIME_MAX);
      // (R04) fall time kept in range
      if (sel_fall)
        fall_r <= clamp_u(wmerge_fall, `SSRS_TIME_MIN, `SSRS_TIME_MAX);
      // (R06) s-curve limited to 100 %
      if (sel_scurve)
        scurve_r <= clamp_u(wmerge_scurve, 16'h0000, `SSRS_PCT_MAX);
      if (sel_thresh)
        thresh_r <= clamp_u(wmerge_thresh, 16'h0000, `SSRS_PCT_MAX);
      if (sel_pre)
        preload_r <= be_merge(preload_r, avs_writedata, avs_byteenable);
      if (sel_minspd)
        minspd_r <= be_merge(minspd_r, avs_writedata, avs_byteenable);
      if (sel_imask && avs_byteenable[0])
        mask_r <= avs_writedata[2:0];
    end
  end

  // ----------------------------------------
  // update tick and run start
  // ----------------------------------------
  logic [CW-1:0] cnt_r;
  logic          en_d_r;
  logic          pend_r;
  wire           tick = cnt_r == CW'(UPDATE_CYCLES - 1);
  // (R11) only a rising enable counts, so disabling never resets
  wire           run_now = pend_r | (drive_enable & ~en_d_r);

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      cnt_r       <= '0;
      en_d_r      <= 1'b0;
      pend_r      <= 1'b0;
      run_start_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= tick ? '0 : cnt_r + 1'b1;
      en_d_r <= drive_enable;
      pend_r <= tick ? 1'b0 : run_now;
      // (R12) run flag stands for exactly one update period
      if (tick)
        run_start_r <= run_now;
    end
  end

  // ----------------------------------------
  // demand shaping
  // ----------------------------------------
  ssrs_acc_t   out_r;
  logic [39:0] rate_r;
  wire         hold   = ctrl_r[`SSRS_CTRL_HOLD];
  wire         auto_on = ctrl_r[`SSRS_CTRL_AUTO];
  wire signed [16:0] dem17 = 17'(inching_modifier_out);
  // (R08) negate demand when invert is set
  wire signed [16:0] inv_d = ctrl_r[`SSRS_CTRL_INVERT] ? -dem17 : dem17;
  wire [16:0]        inv_abs = inv_d[16] ? 17'(-inv_d) : 17'(inv_d);
  wire [16:0]        min17 = {1'b0, minspd_r};
  // (R02) magnitude floor while enabled; sign kept, zero goes positive
  wire               below = drive_enable && (inv_abs < min17);
  wire signed [16:0] target = below ? (inv_d[16] ? -$signed(min17) : $signed(min17)) : inv_d;
  wire ssrs_acc_t    tgt_q = {{7{target[16]}}, target, 16'h0000};
  wire ssrs_acc_t    pre_q = {{8{preload_r[15]}}, preload_r, 16'h0000};

  // ----------------------------------------
  // step size
  // ----------------------------------------
  wire signed [40:0] err     = 41'(tgt_q) - 41'(out_r);
  wire [40:0]        abs_err = err[40] ? 41'(-err) : 41'(err);
  // (R17) away from zero uses rise time, toward zero fall time
  wire               use_rise = (out_r == '0) || (out_r[39] == err[40]);
  wire ssrs_word_t   tsel     = use_rise ? rise_r : fall_r;
  // (R05) time stretched by 1 + 3.5 * s / 100
  wire [16:0]        stretch  = `SSRS_S_BASE + 17'(scurve_r) * `SSRS_S_MUL;
  wire [32:0]        den      = 33'(tsel) * 33'(stretch);
  // (R16) q16 step from span, time and update period
  wire [39:0]        step_q   = `SSRS_STEP_NUM / 40'(den);
  // s-curve: rate eases in, and eases out near the target
  wire [39:0]        soft_up  = rate_r + (step_q >> 4) + 40'h00_0000_0001;
  wire [39:0]        soft_end = 40'(abs_err >> 3) + 40'h00_0000_0001;
  wire [39:0]        soft_a   = (soft_up < step_q) ? soft_up : step_q;
  wire [39:0]        soft_r   = (soft_end < soft_a) ? soft_end : soft_a;
  // (R06) zero s-curve gives the plain linear rate
  wire [39:0]        rate_use = (scurve_r == 16'h0000) ? step_q : soft_r;
  // (R16) last step lands exactly on target
  wire               reach    = abs_err <= 41'(rate_use);
  wire ssrs_acc_t    out_step = reach ? tgt_q :
                                (err[40] ? out_r - $signed(rate_use)
                                         : out_r + $signed(rate_use));
  wire               auto_hit = tick & auto_on & run_now;

  // ----------------------------------------
  // output integrator
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      out_r  <= '0;
      rate_r <= '0;
    end
    // (R13) (R15) external reset level pins output at preload
    else if (ext_reset)
    begin
      out_r  <= pre_q;
      rate_r <= '0;
    end
    // (R10) run start loads preload when auto reset is on
    else if (auto_hit)
    begin
      out_r  <= pre_q;
      rate_r <= '0;
    end
    // (R07) hold freezes, rate restarts softly on release
    else if (tick && hold)
      rate_r <= '0;
    // (R09) (R14) slew from wherever output stands
    else if (tick)
    begin
      out_r  <= out_step;
      rate_r <= reach ? '0 : rate_use;
    end
  end

  assign ramp_output = out_r[31:16];

  // ----------------------------------------
  // activity flag and events
  // ----------------------------------------
  wire signed [17:0] dd     = 18'(inching_modifier_out) - 18'(ramp_output);
  wire [17:0]        abs_dd = dd[17] ? 18'(-dd) : 18'(dd);
  // (R01) compare against modifier output, not shaped target
  wire               act_nxt = abs_dd > 18'(thresh_r);
  wire [2:0]         ev = {tick & run_now, ramp_active & ~act_nxt,
                           ~ramp_active & act_nxt};
  // a read clears, but an event on the same edge survives
  wire [2:0]         iclr = (rd_first && sel_istat) ? 3'h7 : 3'h0;

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      ramp_active <= 1'b0;
      istat_r     <= '0;
    end
    else
    begin
      ramp_active <= act_nxt;
      istat_r     <= (istat_r & ~iclr) | ev;
    end
  end

  assign irq = |(istat_r & mask_r);

  // ----------------------------------------
  // read data
  // ----------------------------------------
  assign rd_mux = sel_ctrl   ? {16'h0000, ctrl_r}   :
                  sel_rise   ? {16'h0000, rise_r}   :
                  sel_fall   ? {16'h0000, fall_r}   :
                  sel_scurve ? {16'h0000, scurve_r} :
                  sel_thresh ? {16'h0000, thresh_r} :
                  sel_pre    ? {16'h0000, preload_r} :
                  sel_minspd ? {16'h0000, minspd_r} :
                  sel_status ? {29'h0, ext_reset, run_start_r, ramp_active} :
                  sel_output ? {16'h0000, ramp_output} :
                  sel_istat  ? {29'h0, istat_r} :
                  sel_imask  ? {29'h0, mask_r} : 32'h0000_0000;

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      avs_readdata <= '0;
    else if (rd_first)
      avs_readdata <= rd_mux;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_active_flag: // (R01)
    assert property (@(posedge clock) disable iff (!reset_n)
      1'b1 |=> ramp_active == ($past(abs_dd) > 18'($past(thresh_r))))
    else $error("activity flag disagrees with threshold");

  chk_min_floor: // (R02)
    assert property (@(posedge clock) disable iff (!reset_n)
      drive_enable |-> ((target[16] ? 17'(-target) : 17'(target)) >= min17))
    else $error("demand below minimum speed while enabled");

  chk_time_range: // (R03)
    assert property (@(posedge clock) disable iff (!reset_n)
      rise_r >= `SSRS_TIME_MIN && rise_r <= `SSRS_TIME_MAX
      && fall_r >= `SSRS_TIME_MIN && fall_r <= `SSRS_TIME_MAX)
    else $error("ramp time out of range");

  chk_linear_rate: // (R06)
    assert property (@(posedge clock) disable iff (!reset_n)
      (scurve_r == 16'h0000) |-> den == 33'(tsel) * 33'(`SSRS_S_BASE)
      && rate_use == step_q)
    else $error("linear ramp rate wrong");

  chk_hold_freeze: // (R07)
    assert property (@(posedge clock) disable iff (!reset_n)
      (hold && !ext_reset && !auto_hit) [*2] |-> $stable(out_r))
    else $error("output moved during hold");

  chk_invert_demand: // (R08)
    assert property (@(posedge clock) disable iff (!reset_n)
      (ctrl_r[`SSRS_CTRL_INVERT] && !drive_enable) |-> target == -dem17)
    else $error("invert not applied");

  chk_between_ticks: // (R09)
    assert property (@(posedge clock) disable iff (!reset_n)
      (!tick && !ext_reset) |=> $stable(out_r))
    else $error("output moved between updates");

  chk_auto_reset: // (R10)
    assert property (@(posedge clock) disable iff (!reset_n)
      (auto_hit && !ext_reset) |=> out_r == $past(pre_q) && run_start_r)
    else $error("auto reset did not load preload");

  chk_run_pulse: // (R12)
    assert property (@(posedge clock) disable iff (!reset_n)
      $changed(run_start_r) |-> $past(tick))
    else $error("run flag changed off the update tick");

  chk_ext_reset: // (R13)
    assert property (@(posedge clock) disable iff (!reset_n)
      ext_reset |=> ramp_output == $past(preload_r))
    else $error("external reset did not hold preload");

  chk_no_overshoot: // (R16)
    assert property (@(posedge clock) disable iff (!reset_n)
      (tick && !hold && !ext_reset && !auto_hit && !err[40])
      |=> out_r <= $past(tgt_q))
    else $error("ramp overshot its target");

  chk_one_wait:
    assert property (@(posedge clock) disable iff (!reset_n)
      (req && avs_waitrequest) |=> !avs_waitrequest)
    else $error("waitrequest held more than one cycle");

endmodule : ssrs_ramp_shaper
`default_nettype wire

// ==== ssrs_defines.svh ====
// ramp shaper register map, field positions, reset values and timing
`ifndef SSRS_DEFINES_SVH
`define SSRS_DEFINES_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SSRS_OFF_CTRL     6'h00
`define SSRS_OFF_RISE     6'h04
`define SSRS_OFF_FALL     6'h08
`define SSRS_OFF_SCURVE   6'h0C
`define SSRS_OFF_THRESH   6'h10
`define SSRS_OFF_PRELOAD  6'h14
`define SSRS_OFF_MINSPD   6'h18
`define SSRS_OFF_STATUS   6'h1C
`define SSRS_OFF_OUTPUT   6'h20
`define SSRS_OFF_IRQ_STAT 6'h24
`define SSRS_OFF_IRQ_MASK 6'h28
// ----------------------------------------
// field positions
// ----------------------------------------
`define SSRS_CTRL_HOLD    0
`define SSRS_CTRL_INVERT  1
`define SSRS_CTRL_AUTO    2
`define SSRS_EV_ROSE      0
`define SSRS_EV_FELL      1
`define SSRS_EV_RUN       2
`define SSRS_EV_W         3
// ----------------------------------------
// reset values (0.1 s and 0.01 % units)
// ----------------------------------------
`define SSRS_RST_CTRL     16'h0004
`define SSRS_RST_RISE     16'h0064
`define SSRS_RST_FALL     16'h0064
`define SSRS_RST_SCURVE   16'h00FA
`define SSRS_RST_THRESH   16'h0032
`define SSRS_RST_PRELOAD  16'h0000
`define SSRS_RST_MINSPD   16'h0000
`define SSRS_RST_MASK     3'h0
// ----------------------------------------
// limits and ramp arithmetic
// ----------------------------------------
`define SSRS_TIME_MIN     16'h0001
`define SSRS_TIME_MAX     16'h1770
`define SSRS_PCT_MAX      16'h2710
// stretch = 20000 + 7*s, i.e. 2*10000*(1 + 3.5*s/10000) with s in 0.01 %
`define SSRS_S_BASE       17'h0_4E20
`define SSRS_S_MUL        17'h0_0007
// q16 step numerator: span 10000 * 2*10000 * 1 ms / 0.1 s
`define SSRS_STEP_NUM     40'h1E_8480_0000
// ----------------------------------------
// update period
// ----------------------------------------
`define SSRS_CLK_NS       32'h0000_0005
`define SSRS_UPDATE_NS    32'h000F_4240
`define SSRS_UPDATE_CYCLES (`SSRS_UPDATE_NS / `SSRS_CLK_NS)
`endif

// ==== ssrs_pkg.sv ====
// ramp shaper shared types
`default_nettype none
package ssrs_pkg;
  typedef logic signed [15:0] ssrs_pct_t;
  typedef logic signed [39:0] ssrs_acc_t;
  typedef logic        [15:0] ssrs_word_t;
endpackage : ssrs_pkg
`default_nettype wire

// ==== ssrs_link_model.sv ====
// demand source upstream and setpoint sink downstream of the ramp shaper
`timescale 1ns/10ps
`default_nettype none
module ssrs_link_model
  import ssrs_pkg::*;
(
  input  wire logic      clock,
  input  wire ssrs_pct_t demand_req,
  input  wire logic      enable_req,
  input  wire logic      reset_req,
  input  wire ssrs_pct_t ramp_output,
  output var  ssrs_pct_t inching_modifier_out,
  output var  logic      drive_enable,
  output var  logic      ext_reset,
  output var  ssrs_pct_t setpoint_seen
);
  // ----------------------------------------
  // registered link, one clock of latency
  // ----------------------------------------
  // level reset, held while asked
  always @(posedge clock)
  begin
    inching_modifier_out <= demand_req;
    drive_enable         <= enable_req;
    ext_reset            <= reset_req;
    setpoint_seen        <= ramp_output;
  end
endmodule : ssrs_link_model
`default_nettype wire

// ==== ssrs_ramp_shaper_tb_top.sv ====
// self-checking bench for the speed setpoint ramp shaper
`timescale 1ns/10ps
`include "ssrs_defines.svh"
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s expected %0h seen %0h", n, e, g); end end
module ssrs_ramp_shaper_tb_top
  import ssrs_pkg::*;
;
  logic        clock           = 1'b0;
  logic        reset_n         = 1'b0;
  logic [5:0]  avs_address     = 6'h00;
  logic        avs_read        = 1'b0;
  logic        avs_write       = 1'b0;
  logic [31:0] avs_writedata   = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  ssrs_pct_t   inching_modifier_out;
  logic        drive_enable;
  logic        ext_reset;
  ssrs_pct_t   ramp_output;
  logic        ramp_active;
  logic        irq;
  ssrs_pct_t   demand_req      = 16'h0000;
  logic        enable_req      = 1'b0;
  logic        reset_req       = 1'b0;
  ssrs_pct_t   setpoint_seen;
  logic [31:0] rd;
  int          failures        = 0;
  int          total_checks    = 0;
  always #2.5 clock = ~clock;
  // short update period keeps the run brief; per-tick step is unchanged
  ssrs_ramp_shaper #(.UPDATE_CYCLES(10)) ssrs_ramp_shaper_i (
    .clock(clock), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .inching_modifier_out(inching_modifier_out),
    .drive_enable(drive_enable), .ext_reset(ext_reset), .ramp_output(ramp_output),
    .ramp_active(ramp_active), .irq(irq));
  ssrs_link_model ssrs_link_model_i (
    .clock(clock), .demand_req(demand_req), .enable_req(enable_req),
    .reset_req(reset_req), .ramp_output(ramp_output),
    .inching_modifier_out(inching_modifier_out), .drive_enable(drive_enable),
    .ext_reset(ext_reset), .setpoint_seen(setpoint_seen));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address   <= a;
    avs_writedata <= {16'h0000, d};
    avs_write     <= wr;
    avs_read      <= ~wr;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      $display("[ERR] waitrequest expected 0 seen 1");
      failures++;
      summarize();
    end
  endtask : bus
  task automatic rchk(input logic [5:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    `CHK("readdata", {16'h0000, e}, rd)
  endtask : rchk
  task automatic drive(input ssrs_pct_t d, input logic e, input logic r);
    @(posedge clock);
    demand_req <= d;
    enable_req <= e;
    reset_req  <= r;
  endtask : drive
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask : idle
  // waits until the output equals v (eq high) or leaves v (eq low)
  task automatic wait_out(input ssrs_pct_t v, input logic eq);
    int n;
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end
    while (((ramp_output === v) !== eq) && n < 8000);
    if (n >= 8000)
    begin
      $display("[ERR] ramp_output expected %0h seen %0h", v, ramp_output);
      failures++;
      summarize();
    end
  endtask : wait_out
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [5:0]  a [9] = '{`SSRS_OFF_CTRL, `SSRS_OFF_RISE, `SSRS_OFF_FALL, `SSRS_OFF_SCURVE,
      `SSRS_OFF_THRESH, `SSRS_OFF_PRELOAD, `SSRS_OFF_MINSPD, `SSRS_OFF_IRQ_MASK, 6'h3C};
    logic [15:0] e [9] = '{16'h0004, 16'h0064, 16'h0064, 16'h00FA, 16'h0032, 16'h0000,
      16'h0000, 16'h0000, 16'h0000};
    for (int i = 0; i < 9; i++)
      rchk(a[i], e[i]);
    bus(1'b1, 6'h3C, 16'h1234);
    rchk(6'h3C, 16'h0000);
    bus(1'b1, `SSRS_OFF_RISE, 16'h0000);
    rchk(`SSRS_OFF_RISE, 16'h0001);
    bus(1'b1, `SSRS_OFF_RISE, 16'h7000);
    rchk(`SSRS_OFF_RISE, 16'h1770);
    bus(1'b1, `SSRS_OFF_FALL, 16'h0000);
    rchk(`SSRS_OFF_FALL, 16'h0001);
    bus(1'b1, `SSRS_OFF_SCURVE, 16'h4E20);
    rchk(`SSRS_OFF_SCURVE, 16'h2710);
    $display("test registers done");
  endtask : t_regs
  task automatic t_linear();
    bus(1'b1, `SSRS_OFF_RISE, 16'h0001);
    bus(1'b1, `SSRS_OFF_FALL, 16'h0002);
    bus(1'b1, `SSRS_OFF_SCURVE, 16'h0000);
    drive(16'h03E8, 1'b1, 1'b0);
    wait_out(16'h0000, 1'b0);
    `CHK("first rise step", 16'h0064, ramp_output)
    idle(2);
    `CHK("active while ramping", 1'b1, ramp_active)
    wait_out(16'h03E8, 1'b1);
    idle(3);
    `CHK("active at target", 1'b0, ramp_active)
    `CHK("setpoint downstream", 16'h03E8, setpoint_seen)
    drive(16'h0000, 1'b1, 1'b0);
    wait_out(16'h03E8, 1'b0);
    `CHK("first fall step", 16'h03B6, ramp_output)
    wait_out(16'h0000, 1'b1);
    drive(16'hFE70, 1'b1, 1'b0);
    wait_out(16'h0000, 1'b0);
    `CHK("rise away from zero", 16'hFF9C, ramp_output)
    wait_out(16'hFE70, 1'b1);
    $display("test linear done");
  endtask : t_linear
  task automatic t_scurve();
    bus(1'b1, `SSRS_OFF_SCURVE, 16'h2710);
    drive(16'h0000, 1'b1, 1'b0);
    wait_out(16'hFE70, 1'b0);
    `CHK("s step above start", 1'b1, ramp_output > 16'shFE70)
    `CHK("s step below linear", 1'b1, ramp_output < 16'shFEA2)
    wait_out(16'h0000, 1'b1);
    bus(1'b1, `SSRS_OFF_SCURVE, 16'h0000);
    $display("test s-curve done");
  endtask : t_scurve
  task automatic t_invert_floor();
    bus(1'b1, `SSRS_OFF_CTRL, 16'h0006);
    drive(16'h012C, 1'b1, 1'b0);
    wait_out(16'hFED4, 1'b1);
    idle(2);
    `CHK("active vs raw demand", 1'b1, ramp_active)
    bus(1'b1, `SSRS_OFF_CTRL, 16'h0004);
    bus(1'b1, `SSRS_OFF_MINSPD, 16'h01F4);
    drive(16'h00C8, 1'b1, 1'b0);
    wait_out(16'h01F4, 1'b1);
    idle(30);
    `CHK("floor target kept", 16'h01F4, ramp_output)
    $display("test invert and floor done");
  endtask : t_invert_floor
  task automatic t_hold();
    bus(1'b1, `SSRS_OFF_PRELOAD, 16'h0100);
    bus(1'b1, `SSRS_OFF_CTRL, 16'h0005);
    // floor cleared only once frozen, so the held value is known
    bus(1'b1, `SSRS_OFF_MINSPD, 16'h0000);
    drive(16'h0000, 1'b1, 1'b0);
    idle(50);
    `CHK("held output", 16'h01F4, ramp_output)
    drive(16'h0000, 1'b1, 1'b1);
    idle(3);
    `CHK("reset beats hold", 16'h0100, ramp_output)
    drive(16'h0000, 1'b1, 1'b0);
    idle(40);
    `CHK("held after reset", 16'h0100, ramp_output)
    bus(1'b1, `SSRS_OFF_CTRL, 16'h0004);
    wait_out(16'h0000, 1'b1);
    $display("test hold done");
  endtask : t_hold
  task automatic t_ext_reset();
    bus(1'b1, `SSRS_OFF_CTRL, 16'h0000);
    drive(16'h03E8, 1'b1, 1'b0);
    wait_out(16'h03E8, 1'b1);
    drive(16'h03E8, 1'b1, 1'b1);
    idle(3);
    `CHK("preload on reset", 16'h0100, ramp_output)
    idle(40);
    `CHK("preload while reset", 16'h0100, ramp_output)
    rchk(`SSRS_OFF_STATUS, 16'h0005);
    drive(16'h03E8, 1'b1, 1'b0);
    wait_out(16'h0100, 1'b0);
    `CHK("resume from preload", 16'h0164, ramp_output)
    bus(1'b1, `SSRS_OFF_CTRL, 16'h0004);
    wait_out(16'h03E8, 1'b1);
    $display("test external reset done");
  endtask : t_ext_reset
  task automatic t_auto_reset();
    bus(1'b0, `SSRS_OFF_IRQ_STAT, 16'h0000);
    bus(1'b1, `SSRS_OFF_IRQ_MASK, 16'h0000);
    drive(16'h03E8, 1'b0, 1'b0);
    idle(40);
    `CHK("no reset on disable", 16'h03E8, ramp_output)
    drive(16'h03E8, 1'b1, 1'b0);
    wait_out(16'h03E8, 1'b0);
    `CHK("preload on run start", 16'h0100, ramp_output)
    bus(1'b0, `SSRS_OFF_STATUS, 16'h0000);
    `CHK("run start flag", 1'b1, rd[1])
    `CHK("masked irq", 1'b0, irq)
    bus(1'b1, `SSRS_OFF_IRQ_MASK, 16'h0004);
    idle(1);
    `CHK("unmasked irq", 1'b1, irq)
    bus(1'b0, `SSRS_OFF_IRQ_STAT, 16'h0000);
    `CHK("run start event", 1'b1, rd[2])
    idle(1);
    `CHK("irq after clear", 1'b0, irq)
    idle(12);
    bus(1'b0, `SSRS_OFF_STATUS, 16'h0000);
    `CHK("run start one period", 1'b0, rd[1])
    wait_out(16'h03E8, 1'b1);
    $display("test auto reset done");
  endtask : t_auto_reset
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    t_regs();
    t_linear();
    t_scurve();
    t_invert_floor();
    t_hold();
    t_ext_reset();
    t_auto_reset();
    summarize();
  end
endmodule : ssrs_ramp_shaper_tb_top
`default_nettype wire
